// ===== tcd_command_decoder.sv
`timescale 1ns/1ns

// Functional notes
// RULE1 - Disable-pool bit clears the addressed tributary's common pool quota to zero.
// RULE2 - Bit 9 stops the addressed tributary from using the shared receive pool.
// RULE3 - Bits 10 and 11 are reserved: host writes zero, device ignores.
// RULE4 - Bit 12 forces the addressed tributary's polling state to active.
// RULE5 - After unlatch, automatic polling algorithm governs that tributary again.
// RULE6 - Bit 13 latches the addressed tributary's polling state to a host level.
// RULE7 - Latched level from parameter bits 1:0: active, inactive, unresponsive, dead.
// RULE8 - Key 00 is a no-op that returns command register ownership to device.
// RULE9 - Host issues null key when granted input but with nothing to post.
// RULE10 - Pool and polling bits still act alongside the null key.
// RULE11 - Key 01 builds a tributary status slot for the given address.
// RULE12 - Host establishes a tributary before any other command naming it.
// RULE13 - Control station host establishes every tributary the network supports.
// RULE14 - Establish address is carried in and read from the tributary address byte.
// RULE15 - Point-to-point stations should establish one tributary at address one.
// RULE16 - Twelve slot blocks, each sixty-four 8-bit status locations.
// RULE17 - Once any tributary exists, one global status slot is created.
// RULE18 - Re-creating a deleted tributary needs establish at both stations.
// RULE19 - Pool and polling bits combine with establish in one command.
module tcd_command_decoder (
    input  wire logic                         i_clk,
    input  wire logic                         i_reset_n,
    input  wire logic                         i_cmd_valid,
    input  wire tcd_pkg::tcd_cmd_t            i_cmd,
    input  wire logic                         i_poll_auto_valid,
    input  wire logic [3:0]                   i_poll_auto_slot,
    input  wire tcd_pkg::tcd_poll_t           i_poll_auto_level,
    input  wire logic [3:0]                   i_status_sel,
    input  wire logic [5:0]                   i_slot_rd_addr,
    output logic                              o_input_request_grant,
    output logic                              o_cmd_done,
    output logic                              o_cmd_error,
    output tcd_pkg::tcd_slot_status_t         o_slot_status,
    output logic [7:0]                        o_slot_rd_data,
    output logic                              o_global_status_slot_valid,
    output logic [3:0]                        o_slots_used
);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    tcd_pkg::tcd_state_t state_ff;
    tcd_pkg::tcd_state_t nxt_state;
    tcd_pkg::tcd_cmd_t   cmd_ff;
    tcd_pkg::tcd_poll_t  latch_level;

    logic [tcd_pkg::NUM_SLOTS-1:0]  est_ff;
    logic [tcd_pkg::NUM_SLOTS-1:0]  latched_ff;
    logic [tcd_pkg::NUM_SLOTS-1:0]  pool_en_ff;
    logic [7:0]                     addr_tag_ff [tcd_pkg::NUM_SLOTS];
    logic [7:0]                     quota_ff    [tcd_pkg::NUM_SLOTS];
    tcd_pkg::tcd_poll_t             poll_ff     [tcd_pkg::NUM_SLOTS];
    logic [7:0]                     slot_mem    [tcd_pkg::NUM_SLOTS*tcd_pkg::SLOT_WORDS];
    logic                           gss_ff;
    logic [7:0]                     rd_data_ff;
    logic                           done_ff;
    logic                           err_ff;

    logic [4:0]  key;
    logic        bit_pool_en;
    logic        bit_pool_dis;
    logic        bit_unlatch;
    logic        bit_latch;
    logic        hit;
    logic [3:0]  hit_idx;
    logic        free;
    logic [3:0]  free_idx;
    logic        is_est;
    logic        is_null;
    logic        tgt_ok;
    logic [3:0]  tgt_idx;
    logic        exec;
    logic [8:0]  quota_sum;
    logic        opt_bits;
    logic        quota_ovf;
    logic        auto_ok;
    logic        cmd_poll;

    // Bits 10 and 11 are never looked at  // RULE3
    assign key          = cmd_ff.control_command_word[tcd_pkg::CMD_KEY_LSB +: tcd_pkg::CMD_KEY_W];
    assign bit_pool_en  = cmd_ff.control_command_word[tcd_pkg::CMD_BIT_POOL_EN];
    assign bit_pool_dis = cmd_ff.control_command_word[tcd_pkg::CMD_BIT_POOL_DIS];  // RULE2
    assign bit_unlatch  = cmd_ff.control_command_word[tcd_pkg::CMD_BIT_UNLATCH];
    assign bit_latch    = cmd_ff.control_command_word[tcd_pkg::CMD_BIT_LATCH];
    assign is_est       = (key == tcd_pkg::KEY_ESTABLISH);
    assign is_null      = (key == tcd_pkg::KEY_NULL);
    assign exec         = (state_ff == tcd_pkg::TCD_ST_EXEC);

    // Address lookup over established slots, plus first free slot
    always_comb begin
        hit      = 1'b0;
        hit_idx  = 4'h0;
        free     = 1'b0;
        free_idx = 4'h0;
        for (int i = tcd_pkg::NUM_SLOTS - 1; i >= 0; i--) begin
            if (est_ff[i] && addr_tag_ff[i] == cmd_ff.tributary_address_byte) begin  // RULE14
                hit     = 1'b1;
                hit_idx = 4'(i);
            end
            if (!est_ff[i]) begin
                free     = 1'b1;
                free_idx = 4'(i);
            end
        end
    end

    // Establish of an existing address reuses its slot
    always_comb begin
        tgt_ok  = hit;
        tgt_idx = hit_idx;
        if (is_est && !hit) begin
            tgt_ok  = free;  // RULE16
            tgt_idx = free_idx;
        end
    end

    // Nine bits so the carry out of the addition is kept
    assign quota_sum = {1'b0, quota_ff[tgt_idx]} + {1'b0, cmd_ff.command_parameter_byte};

    // An unlimited request never counts as an overflow
    assign quota_ovf = bit_pool_en
                       && cmd_ff.command_parameter_byte != tcd_pkg::QUOTA_UNLIMITED
                       && quota_sum >= {1'b0, tcd_pkg::QUOTA_UNLIMITED};
    assign opt_bits  = bit_pool_en || bit_pool_dis || bit_latch || bit_unlatch;
    assign latch_level = tcd_pkg::tcd_poll_t'(cmd_ff.command_parameter_byte[1:0]);  // RULE7

    // ------------------------------------------------------------
    // Command sequencing
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            tcd_pkg::TCD_ST_IDLE: begin
                if (i_cmd_valid) begin
                    nxt_state = tcd_pkg::TCD_ST_EXEC;
                end
            end
            tcd_pkg::TCD_ST_EXEC: begin
                nxt_state = tcd_pkg::TCD_ST_DONE;
            end
            tcd_pkg::TCD_ST_DONE: begin
                nxt_state = tcd_pkg::TCD_ST_IDLE;
            end
            default: begin
                nxt_state = tcd_pkg::TCD_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_ff <= tcd_pkg::TCD_ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Command registers are the device's again once DONE passes
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cmd_ff <= '0;
        end else if (state_ff == tcd_pkg::TCD_ST_IDLE && i_cmd_valid) begin
            cmd_ff <= i_cmd;
        end
    end

    // Low through EXEC and DONE, so a valid held by the host is not retaken
    assign o_input_request_grant = (state_ff == tcd_pkg::TCD_ST_IDLE);  // RULE8

    // Unknown keys and missing tributaries flag an error but still complete
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            done_ff <= 1'b0;
            err_ff  <= 1'b0;
        end else begin
            done_ff <= exec;
            err_ff  <= exec && (!(is_null || is_est)
                       || (!tgt_ok && (is_est || opt_bits))
                       || (tgt_ok && quota_ovf));
        end
    end

    assign o_cmd_done  = done_ff;
    assign o_cmd_error = err_ff;

    // ------------------------------------------------------------
    // Slot table
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            est_ff <= '0;
            for (int i = 0; i < tcd_pkg::NUM_SLOTS; i++) begin
                addr_tag_ff[i] <= 8'h00;
            end
        end else if (exec && is_est && tgt_ok) begin  // RULE11
            est_ff[tgt_idx]      <= 1'b1;
            addr_tag_ff[tgt_idx] <= cmd_ff.tributary_address_byte;  // RULE14
        end
    end

    // Option bits act with null or establish key alike
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pool_en_ff <= '0;
            for (int i = 0; i < tcd_pkg::NUM_SLOTS; i++) begin
                quota_ff[i] <= tcd_pkg::QUOTA_RESET;
            end
        end else if (exec && tgt_ok && (is_null || is_est)) begin  // RULE10 RULE19
            if (is_est && !hit) begin
                pool_en_ff[tgt_idx] <= 1'b0;
                quota_ff[tgt_idx]   <= tcd_pkg::QUOTA_RESET;
            end
            if (bit_pool_dis) begin
                pool_en_ff[tgt_idx] <= 1'b0;  // RULE2
                quota_ff[tgt_idx]   <= tcd_pkg::QUOTA_RESET;  // RULE1
            end else if (bit_pool_en) begin
                pool_en_ff[tgt_idx] <= 1'b1;
                if (cmd_ff.command_parameter_byte == tcd_pkg::QUOTA_UNLIMITED) begin
                    quota_ff[tgt_idx] <= tcd_pkg::QUOTA_UNLIMITED;
                end else if (quota_ovf) begin
                    quota_ff[tgt_idx] <= tcd_pkg::QUOTA_MAX_LEGAL;
                end else begin
                    quota_ff[tgt_idx] <= quota_sum[7:0];
                end
            end
        end
    end

    // Latch wins over unlatch if both are set. An automatic update to
    // another slot in the same cycle still lands; on the same slot the
    // command is written last and so takes precedence.
    assign auto_ok  = i_poll_auto_valid && i_poll_auto_slot < 4'(tcd_pkg::NUM_SLOTS)
                      && !latched_ff[i_poll_auto_slot];
    assign cmd_poll = exec && tgt_ok && (is_null || is_est)
                      && (bit_latch || bit_unlatch || (is_est && !hit));

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            latched_ff <= '0;
            for (int i = 0; i < tcd_pkg::NUM_SLOTS; i++) begin
                poll_ff[i] <= tcd_pkg::TCD_POLL_ACTIVE;
            end
        end else begin
            if (auto_ok) begin
                poll_ff[i_poll_auto_slot] <= i_poll_auto_level;  // RULE5
            end
            if (cmd_poll) begin
                if (bit_latch) begin
                    latched_ff[tgt_idx] <= 1'b1;  // RULE6
                    poll_ff[tgt_idx]    <= latch_level;
                end else begin
                    latched_ff[tgt_idx] <= 1'b0;  // RULE5
                    poll_ff[tgt_idx]    <= tcd_pkg::TCD_POLL_ACTIVE;  // RULE4
                end
            end
        end
    end

    // A new slot's words are not swept to zero: the sweep would hold off
    // commands for a whole slot's worth of cycles. Only word 0 is written
    // here; the rest belongs to the protocol engine.
    always_ff @(posedge i_clk) begin
        rd_data_ff <= slot_mem[{i_status_sel, i_slot_rd_addr}];  // RULE16
    end

    always_ff @(posedge i_clk) begin
        if (exec && is_est && tgt_ok) begin
            slot_mem[{tgt_idx, 6'h00}] <= cmd_ff.tributary_address_byte;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            gss_ff <= 1'b0;
        end else if (exec && is_est && tgt_ok) begin
            gss_ff <= 1'b1;  // RULE17
        end
    end

    // ------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------
    always_comb begin
        o_slots_used = 4'h0;
        for (int i = 0; i < tcd_pkg::NUM_SLOTS; i++) begin
            o_slots_used = o_slots_used + 4'(est_ff[i]);
        end
    end

    always_comb begin
        o_slot_status = '0;
        if (i_status_sel < 4'(tcd_pkg::NUM_SLOTS)) begin
            o_slot_status.established  = est_ff[i_status_sel];
            o_slot_status.poll_latched = latched_ff[i_status_sel];
            o_slot_status.poll_level   = poll_ff[i_status_sel];
            o_slot_status.pool_enabled = pool_en_ff[i_status_sel];
            o_slot_status.pool_quota   = quota_ff[i_status_sel];
        end
    end

    assign o_slot_rd_data             = rd_data_ff;
    assign o_global_status_slot_valid = gss_ff;

endmodule

// ===== tcd_pkg.sv
package tcd_pkg;

    // ------------------------------------------------------------
    // Command word fields
    // ------------------------------------------------------------
    localparam int CMD_KEY_LSB      = 0;
    localparam int CMD_KEY_W        = 5;
    localparam int CMD_BIT_POOL_EN  = 8;
    localparam int CMD_BIT_POOL_DIS = 9;
    localparam int CMD_BIT_UNLATCH  = 12;
    localparam int CMD_BIT_LATCH    = 13;

    localparam logic [4:0] KEY_NULL      = 5'h00;
    localparam logic [4:0] KEY_ESTABLISH = 5'h01;

    // ------------------------------------------------------------
    // Slot sizing and reset values
    // ------------------------------------------------------------
    localparam int NUM_SLOTS      = 12;
    localparam int SLOT_WORDS     = 64;
    localparam int SLOT_IDX_W     = 4;
    localparam int SLOT_WORD_W    = 6;
    localparam logic [7:0] QUOTA_RESET    = 8'h00;
    localparam logic [7:0] QUOTA_MAX_LEGAL = 8'hfe;
    localparam logic [7:0] QUOTA_UNLIMITED = 8'hff;

    typedef enum logic [1:0] {
        TCD_POLL_ACTIVE       = 2'b00,
        TCD_POLL_INACTIVE     = 2'b01,
        TCD_POLL_UNRESPONSIVE = 2'b10,
        TCD_POLL_DEAD         = 2'b11
    } tcd_poll_t;

    typedef enum logic [1:0] {
        TCD_ST_IDLE = 2'b00,
        TCD_ST_EXEC = 2'b01,
        TCD_ST_DONE = 2'b10
    } tcd_state_t;

    // One posted command
    typedef struct packed {
        logic [15:0] control_command_word;
        logic [7:0]  tributary_address_byte;
        logic [7:0]  command_parameter_byte;
    } tcd_cmd_t;

    // Per-slot status seen outside
    typedef struct packed {
        logic       established;
        logic       poll_latched;
        tcd_poll_t  poll_level;
        logic       pool_enabled;
        logic [7:0] pool_quota;
    } tcd_slot_status_t;

endpackage

// ===== tcd_chk.sv
`timescale 1ns/1ns
module tcd_chk (
    input wire logic                      i_clk,
    input wire logic                      i_reset_n,
    input wire logic                      i_cmd_valid,
    input wire tcd_pkg::tcd_cmd_t         i_cmd,
    input wire logic                      i_poll_auto_valid,
    input wire logic [3:0]                i_poll_auto_slot,
    input wire tcd_pkg::tcd_poll_t        i_poll_auto_level,
    input wire logic [3:0]                i_status_sel,
    input wire logic [5:0]                i_slot_rd_addr,
    input wire logic                      o_input_request_grant,
    input wire logic                      o_cmd_done,
    input wire logic                      o_cmd_error,
    input wire tcd_pkg::tcd_slot_status_t o_slot_status,
    input wire logic [7:0]                o_slot_rd_data,
    input wire logic                      o_global_status_slot_valid,
    input wire logic [3:0]                o_slots_used
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    logic take;
    assign take = o_input_request_grant && i_cmd_valid;
    // ------------------------------------------------------------
    // Command handshake
    // ------------------------------------------------------------
    sequence s_exec;
        !o_input_request_grant ##1 (o_cmd_done && !o_input_request_grant) ##1 o_input_request_grant;
    endsequence
    sequence s_bad_key;
        take ##0 (i_cmd.control_command_word[4:0] > 5'h01);
    endsequence
    chk_take_then_done: assert property (take |=> s_exec)
        else $error("command not finished two cycles after being taken");
    chk_done_has_cause: assert property (o_cmd_done |-> $past(take, 2))
        else $error("done without a command taken two cycles before");
    chk_bad_key_err: assert property (s_bad_key |-> ##2 (o_cmd_done && o_cmd_error))
        else $error("unknown request key not refused");
    // ------------------------------------------------------------
    // Slot state
    // ------------------------------------------------------------
    chk_quota_by_cmd: assert property ($changed(o_slot_status.pool_quota) && $stable(i_status_sel)
        |-> o_cmd_done) else $error("pool quota moved without a command");
    chk_pool_off_zero: assert property (!o_slot_status.pool_enabled
        |-> o_slot_status.pool_quota == 8'h00) else $error("disabled pool keeps a quota");
    chk_latch_holds: assert property ($past(o_slot_status.poll_latched) && $stable(i_status_sel)
        && $changed(o_slot_status.poll_level) |-> o_cmd_done) else $error("latched level moved");
    chk_unlatch_active: assert property ($fell(o_slot_status.poll_latched) && $stable(i_status_sel)
        |-> o_slot_status.poll_level == tcd_pkg::TCD_POLL_ACTIVE) else $error("unlatch not active");
    chk_gss_on_est: assert property ($rose(o_global_status_slot_valid)
        |-> o_cmd_done && !o_cmd_error) else $error("global slot appeared without establish");
    chk_slots_step: assert property ($changed(o_slots_used) |-> o_cmd_done
        && o_slots_used == $past(o_slots_used) + 4'h1) else $error("slot count moved wrongly");
endmodule

bind tcd_command_decoder tcd_chk i_chk (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .i_poll_auto_valid(i_poll_auto_valid),
    .i_poll_auto_slot(i_poll_auto_slot), .i_poll_auto_level(i_poll_auto_level),
    .i_status_sel(i_status_sel), .i_slot_rd_addr(i_slot_rd_addr),
    .o_input_request_grant(o_input_request_grant), .o_cmd_done(o_cmd_done),
    .o_cmd_error(o_cmd_error), .o_slot_status(o_slot_status), .o_slot_rd_data(o_slot_rd_data),
    .o_global_status_slot_valid(o_global_status_slot_valid), .o_slots_used(o_slots_used));

// ===== tcd_host.sv
`timescale 1ns/1ns
module tcd_host (
    input  wire logic         i_clk,
    input  wire logic         i_grant,
    input  wire logic         i_done,
    input  wire logic         i_error,
    output tcd_pkg::tcd_cmd_t o_cmd,
    output logic              o_valid
);
    initial begin
        o_valid = 1'b0;
        o_cmd   = '0;
    end
    // ------------------------------------------------------------
    // Post one command and return its error flag
    // ------------------------------------------------------------
    task automatic post(input tcd_pkg::tcd_cmd_t c, output logic err);
        logic g;
        int   n;
        @(posedge i_clk);
        o_valid <= 1'b1;
        o_cmd   <= c;
        n = 0;
        do begin
            @(negedge i_clk);
            g = i_grant;
            n++;
            @(posedge i_clk);
        end while (g !== 1'b1 && n < 50);
        o_valid <= 1'b0;
        // Scrambled so a stale word never passes for a live one
        o_cmd   <= ~c;
        @(negedge i_clk);
        @(negedge i_clk);
        err = (i_done === 1'b1) ? i_error : 1'bx;
    endtask
endmodule

// ===== tributary_control_command_decoder_tb.sv
`timescale 1ns/1ns
module tributary_control_command_decoder_tb;
    logic                      i_clk = 1'b0;
    logic                      i_reset_n = 1'b0;
    logic                      auto_v = 1'b0;
    logic [3:0]                auto_s = 4'h0;
    tcd_pkg::tcd_poll_t        auto_l = tcd_pkg::TCD_POLL_ACTIVE;
    logic [3:0]                i_status_sel = 4'h0;
    logic [5:0]                i_slot_rd_addr = 6'h00;
    logic                      valid;
    logic                      grant;
    logic                      done;
    logic                      error;
    logic                      global_status_slot;
    logic [3:0]                used;
    logic [7:0]                rd_data;
    tcd_pkg::tcd_cmd_t         cmd;
    tcd_pkg::tcd_slot_status_t status;
    int                        num_errors = 0;
    int                        checks = 0;

    always #20 i_clk = ~i_clk;

    tcd_command_decoder i_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_cmd_valid(valid),
        .i_cmd(cmd), .i_poll_auto_valid(auto_v), .i_poll_auto_slot(auto_s),
        .i_poll_auto_level(auto_l), .i_status_sel(i_status_sel), .i_slot_rd_addr(i_slot_rd_addr),
        .o_input_request_grant(grant), .o_cmd_done(done), .o_cmd_error(error),
        .o_slot_status(status), .o_slot_rd_data(rd_data), .o_global_status_slot_valid(global_status_slot),
        .o_slots_used(used));
    tcd_host i_host (.i_clk(i_clk), .i_grant(grant), .i_done(done), .i_error(error),
        .o_cmd(cmd), .o_valid(valid));

    // ------------------------------------------------------------
    // Access and compare tasks
    // ------------------------------------------------------------
    task automatic cmp_v(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_b(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic cmp_st(input tcd_pkg::tcd_slot_status_t exp);
        @(negedge i_clk);
        checks++;
        if (status !== exp) begin
            num_errors++;
            $display("[FAIL] %0t slot status %h expected %h", $time, status, exp);
        end
    endtask
    function automatic tcd_pkg::tcd_slot_status_t st(input logic l, input logic [1:0] p,
                                                     input logic e, input logic [7:0] q);
        return {1'b1, l, tcd_pkg::tcd_poll_t'(p), e, q};
    endfunction
    task automatic run(input logic [15:0] w, input logic [7:0] a, input logic [7:0] p,
                       input logic exp_err);
        logic e;
        i_host.post({w, a, p}, e);
        cmp_b(e, exp_err);
    endtask
    task automatic cmp_mem(input logic [3:0] s, input logic [7:0] exp);
        @(posedge i_clk);
        i_status_sel <= s;
        i_slot_rd_addr <= 6'h00;
        @(posedge i_clk);
        @(negedge i_clk);
        cmp_v(rd_data, exp);
    endtask
    task automatic auto_upd(input logic [3:0] s, input logic [1:0] l);
        @(posedge i_clk);
        auto_v <= 1'b1;
        auto_s <= s;
        auto_l <= tcd_pkg::tcd_poll_t'(l);
        @(posedge i_clk);
        auto_v <= 1'b0;
    endtask
    task automatic results();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge i_clk);
        num_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        results();
    end

    initial begin
        repeat (5) @(posedge i_clk);
        i_reset_n <= 1'b1;
        cmp_st('0);
        cmp_b(grant, 1'b1);
        cmp_b(global_status_slot, 1'b0);
        run(16'h0000, 8'h00, 8'h00, 1'b0);
        cmp_b(global_status_slot, 1'b0);
        $display("test reset_null done");
        run(16'h0101, 8'h01, 8'h05, 1'b0);
        cmp_st(st(1'b0, 2'b00, 1'b1, 8'h05));
        cmp_b(global_status_slot, 1'b1);
        cmp_v({4'h0, used}, 8'h01);
        cmp_mem(4'h0, 8'h01);
        $display("test establish done");
        for (int i = 0; i < 4; i++) begin
            run(16'h2c00, 8'h01, 8'(i), 1'b0);
            cmp_st(st(1'b1, 2'(i), 1'b1, 8'h05));
        end
        auto_upd(4'h0, 2'b01);
        cmp_st(st(1'b1, 2'b11, 1'b1, 8'h05));
        run(16'h1001, 8'h01, 8'h00, 1'b0);
        cmp_st(st(1'b0, 2'b00, 1'b1, 8'h05));
        cmp_v({4'h0, used}, 8'h01);
        auto_upd(4'h0, 2'b11);
        cmp_st(st(1'b0, 2'b11, 1'b1, 8'h05));
        $display("test polling done");
        run(16'h0100, 8'h01, 8'hfa, 1'b1);
        cmp_st(st(1'b0, 2'b11, 1'b1, 8'hfe));
        run(16'h0100, 8'h01, 8'hff, 1'b0);
        cmp_st(st(1'b0, 2'b11, 1'b1, 8'hff));
        run(16'h0300, 8'h01, 8'hff, 1'b0);
        cmp_st(st(1'b0, 2'b11, 1'b0, 8'h00));
        $display("test pool done");
        run(16'h0002, 8'h01, 8'h00, 1'b1);
        run(16'h2000, 8'h09, 8'h03, 1'b1);
        cmp_st(st(1'b0, 2'b11, 1'b0, 8'h00));
        for (int a = 2; a <= 12; a++) begin
            run(16'h0001, 8'(a), 8'h00, 1'b0);
        end
        cmp_v({4'h0, used}, 8'h0c);
        run(16'h0001, 8'h0d, 8'h00, 1'b1);
        cmp_v({4'h0, used}, 8'h0c);
        cmp_mem(4'hb, 8'h0c);
        cmp_st(st(1'b0, 2'b00, 1'b0, 8'h00));
        auto_upd(4'hb, 2'b01);
        cmp_st(st(1'b0, 2'b01, 1'b0, 8'h00));
        run(16'h3000, 8'h0c, 8'h02, 1'b0);
        cmp_st(st(1'b1, 2'b10, 1'b0, 8'h00));
        auto_upd(4'hb, 2'b11);
        cmp_st(st(1'b1, 2'b10, 1'b0, 8'h00));
        $display("test fill done");
        @(posedge i_clk);
        i_reset_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_reset_n <= 1'b1;
        cmp_st('0);
        cmp_v({4'h0, used}, 8'h00);
        cmp_b(global_status_slot, 1'b0);
        run(16'h0000, 8'h00, 8'h00, 1'b0);
        $display("test mid_reset done");
        results();
    end
endmodule
